/* sbf_fault_config.sv */
// fault configuration registers and supply and lock fault supervisor
//
// Notes on behaviour
// [R1] lock detect deglitch: code 0 none, codes 1-7 give that many microseconds.
// [R2] supply below chosen floor is a fault; code 0 disables; 4.5 to 12.5 V.
// [R3] undervoltage recovery bit: 0 latches fault, 1 clears once supply in bounds.
// [R4] supply above chosen ceiling is a fault; code 0 disables; 20 to 35 V.
// [R5] overvoltage recovery bit: 0 latches fault, 1 clears once supply in bounds.
// [R6] retry limit code: 0 unlimited, else 2,3,5,7,10,15,20 attempts.
// [R7] software leaves unlisted configuration addresses alone; they read zero.
// [R8] writing one to a clear-on-one status bit clears it.
// [R9] auto lock modes clear after retry wait; beyond limit, latch and tristate.
// [R10] latched lock modes latch, assert fault output, tristate or brake gates.
// [R11] lock event only after condition persists the whole deglitch time.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module sbf_fault_config
  import sbf_pkg::*;
#(
  parameter int LOCK_RETRY_WAIT_US = 1000,
  parameter int LOCK_RETRY_CYCLES  = LOCK_RETRY_WAIT_US * CYC_PER_US
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [15:0] supply_mv,
  input  wire logic        lock_detect,
  output logic             fault_indicator_out_n,
  output logic             gate_tristate,
  output logic             gate_brake_high,
  output logic             gate_brake_low
);

  localparam logic [31:0] RETRY_LAST = 32'(LOCK_RETRY_CYCLES - 1);

  // configuration storage
  logic [31:0] pin_function_setup_reg;
  logic [31:0] device_setup_a_reg;
  logic [31:0] device_setup_b_reg;
  logic [31:0] peripheral_setup_a_reg;
  logic [31:0] gate_driver_setup_a_reg;
  logic [31:0] gate_driver_setup_b_reg;
  logic [31:0] fault_setup_b_reg;

  // fault state
  logic             uv_fault_reg;
  logic             ov_fault_reg;
  logic             lock_fault_reg;
  logic             lock_report_reg;
  logic [CNT_W-1:0] retry_cnt_reg;
  logic [31:0]      wait_cnt_reg;
  logic [1:0]       lock_action_reg;
  sbf_lock_state_t  lock_state_reg;
  logic             lock_seen_d_reg;

  // bus pipeline
  logic             wr_pend_reg;
  logic             rd_pend_reg;
  logic [ADDR_W-1:0] addr_reg;

  // decoded fields
  logic [3:0] lock_current_response_select;
  logic [2:0] supply_floor_level;
  logic [2:0] supply_ceiling_level;
  logic       undervolt_recovery_select;
  logic       overvolt_recovery_select;
  logic [2:0] retry_attempt_limit;
  logic       below_floor;
  logic       above_ceiling;
  logic       lock_event;
  logic       lock_acting;
  logic       lock_auto;
  logic       st_wr;
  logic       fb_wr;
  logic       clr_uv;
  logic       clr_ov;
  logic       clr_lock;
  logic       clr_rpt;
  logic       retry_ok;
  logic [4:0] limit;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  sbf_lock_if lk ();

  sbf_lock_filter u_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .lk      (lk.filt)
  );

  // field extraction from fault_setup_b
  assign lock_current_response_select = fault_setup_b_reg[LKM_LSB +: 4];
  assign lk.lock_current_deglitch     = fault_setup_b_reg[DEG_LSB +: 3];
  assign supply_floor_level           = fault_setup_b_reg[MIN_LSB +: 3];
  assign undervolt_recovery_select    = fault_setup_b_reg[UVR_BIT];
  assign supply_ceiling_level         = fault_setup_b_reg[MAX_LSB +: 3];
  assign overvolt_recovery_select     = fault_setup_b_reg[OVR_BIT];
  assign retry_attempt_limit          = fault_setup_b_reg[RTY_LSB +: 3];
  assign lk.lock_raw                  = lock_detect;

  // supply window comparisons, code zero never trips
  assign below_floor   = (supply_floor_level != 3'h0) &&
                         (supply_mv < sbf_floor_mv(supply_floor_level)); // [R2]
  assign above_ceiling = (supply_ceiling_level != 3'h0) &&
                         (supply_mv > sbf_ceiling_mv(supply_ceiling_level)); // [R4]

  // lock mode decode: codes below 8 act, 8 reports, above disabled
  assign lock_acting = !lock_current_response_select[3];
  assign lock_auto   = lock_current_response_select[2];
  assign lock_event  = lk.lock_seen && !lock_seen_d_reg; // [R11]

  // retry budget
  assign limit    = sbf_retry_limit(retry_attempt_limit);
  assign retry_ok = (limit == 5'h00) || (retry_cnt_reg < limit); // [R6]

  // write strobes for the data phase
  assign st_wr    = wr_pend_reg && (addr_reg == {IDX_FAULT_STATUS, 2'b00});
  assign fb_wr    = wr_pend_reg && (addr_reg == {IDX_FAULT_SETUP_B, 2'b00});
  assign clr_uv   = st_wr && hwdata[ST_UV_BIT]; // [R8]
  assign clr_ov   = st_wr && hwdata[ST_OV_BIT]; // [R8]
  assign clr_lock = st_wr && hwdata[ST_LOCK_BIT]; // [R8]
  assign clr_rpt  = st_wr && hwdata[ST_RPT_BIT]; // [R8]

  // ahb slave: zero-wait writes, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
    end else if (ce) begin
      if (hready) begin
        wr_pend_reg <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
        rd_pend_reg <= hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
        addr_reg    <= haddr[ADDR_W-1:0];
      end else begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
      end
    end
  end

  // read data sampled in the wait cycle so a prior write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ce && rd_pend_reg) begin
      hrdata <= rd_mux;
    end
  end

  assign hreadyout = !rd_pend_reg;
  assign hresp     = 1'b0;

  assign status_word = {{(32 - ST_CNT_LSB - CNT_W){1'b0}}, retry_cnt_reg,
                        lock_report_reg, lock_fault_reg, ov_fault_reg, uv_fault_reg};

  // read decode; unlisted addresses read zero
  always_comb begin
    rd_mux = 32'h00000000; // [R7]
    if (addr_reg == {IDX_PIN_FUNCTION_SETUP, 2'b00}) begin
      rd_mux = pin_function_setup_reg;
    end else if (addr_reg == {IDX_DEVICE_SETUP_A, 2'b00}) begin
      rd_mux = device_setup_a_reg;
    end else if (addr_reg == {IDX_DEVICE_SETUP_B, 2'b00}) begin
      rd_mux = device_setup_b_reg;
    end else if (addr_reg == {IDX_PERIPHERAL_SETUP_A, 2'b00}) begin
      rd_mux = peripheral_setup_a_reg;
    end else if (addr_reg == {IDX_GATE_DRIVER_SETUP_A, 2'b00}) begin
      rd_mux = gate_driver_setup_a_reg;
    end else if (addr_reg == {IDX_GATE_DRIVER_SETUP_B, 2'b00}) begin
      rd_mux = gate_driver_setup_b_reg;
    end else if (addr_reg == {IDX_FAULT_SETUP_B, 2'b00}) begin
      rd_mux = fault_setup_b_reg;
    end else if (addr_reg == {IDX_FAULT_STATUS, 2'b00}) begin
      rd_mux = status_word;
    end
  end

  // plain setup storage, consumed elsewhere in the device
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_function_setup_reg  <= SETUP_RESET;
      device_setup_a_reg      <= SETUP_RESET;
      device_setup_b_reg      <= SETUP_RESET;
      peripheral_setup_a_reg  <= SETUP_RESET;
      gate_driver_setup_a_reg <= SETUP_RESET;
      gate_driver_setup_b_reg <= SETUP_RESET;
    end else if (ce && wr_pend_reg) begin
      if (addr_reg == {IDX_PIN_FUNCTION_SETUP, 2'b00}) pin_function_setup_reg <= hwdata;
      if (addr_reg == {IDX_DEVICE_SETUP_A, 2'b00}) device_setup_a_reg <= hwdata;
      if (addr_reg == {IDX_DEVICE_SETUP_B, 2'b00}) device_setup_b_reg <= hwdata;
      if (addr_reg == {IDX_PERIPHERAL_SETUP_A, 2'b00}) peripheral_setup_a_reg <= hwdata;
      if (addr_reg == {IDX_GATE_DRIVER_SETUP_A, 2'b00}) gate_driver_setup_a_reg <= hwdata;
      if (addr_reg == {IDX_GATE_DRIVER_SETUP_B, 2'b00}) gate_driver_setup_b_reg <= hwdata;
    end
  end

  // fault configuration, reserved bits forced to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_setup_b_reg <= FAULT_B_RESET;
    end else if (ce && fb_wr) begin
      fault_setup_b_reg <= hwdata & FAULT_B_MASK;
    end
  end

  // undervoltage: set beats clear, auto mode drops once back in bounds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_fault_reg <= 1'b0;
    end else if (ce) begin
      if (below_floor) begin
        uv_fault_reg <= 1'b1; // [R2]
      end else if (undervolt_recovery_select || clr_uv) begin
        uv_fault_reg <= 1'b0; // [R3] [R8]
      end
    end
  end

  // overvoltage: same recovery scheme as undervoltage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_fault_reg <= 1'b0;
    end else if (ce) begin
      if (above_ceiling) begin
        ov_fault_reg <= 1'b1; // [R4]
      end else if (overvolt_recovery_select || clr_ov) begin
        ov_fault_reg <= 1'b0; // [R5] [R8]
      end
    end
  end

  // report-only lock events just leave a sticky flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_report_reg <= 1'b0;
      lock_seen_d_reg <= 1'b0;
    end else if (ce) begin
      lock_seen_d_reg <= lk.lock_seen;
      if (lock_event && (lock_current_response_select == LKM_REPORT)) begin
        lock_report_reg <= 1'b1;
      end else if (clr_rpt) begin
        lock_report_reg <= 1'b0; // [R8]
      end
    end
  end

  // lock fault sequencer; a new event in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_state_reg  <= SBF_LK_IDLE;
      lock_fault_reg  <= 1'b0;
      lock_action_reg <= 2'h0;
      retry_cnt_reg   <= '0;
      wait_cnt_reg    <= 32'h00000000;
    end else if (ce) begin
      if (clr_lock && !(lock_event && lock_acting)) begin
        lock_state_reg <= SBF_LK_IDLE; // [R8]
        lock_fault_reg <= 1'b0;
        retry_cnt_reg  <= '0;
        wait_cnt_reg   <= 32'h00000000;
      end else begin
        unique case (lock_state_reg)
          SBF_LK_IDLE: begin
            if (lock_event && lock_acting) begin
              lock_fault_reg  <= 1'b1; // [R10]
              lock_action_reg <= lock_current_response_select[1:0]; // [R10]
              wait_cnt_reg    <= 32'h00000000;
              lock_state_reg  <= lock_auto ? SBF_LK_WAIT : SBF_LK_LATCH;
            end
          end
          SBF_LK_WAIT: begin
            if (wait_cnt_reg < RETRY_LAST) begin
              wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
            end else if (retry_ok) begin
              lock_fault_reg <= 1'b0; // [R9]
              retry_cnt_reg  <= retry_cnt_reg + 1'b1; // [R6]
              lock_state_reg <= SBF_LK_IDLE;
            end else begin
              lock_action_reg <= 2'h0; // [R9]
              lock_state_reg  <= SBF_LK_LATCH;
            end
          end
          SBF_LK_LATCH: begin
            lock_fault_reg <= 1'b1; // [R10]
          end
          default: begin
            lock_state_reg <= SBF_LK_IDLE;
          end
        endcase
      end
    end
  end

  // gate and fault pin drive from the latched fault state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_indicator_out_n <= 1'b1;
      gate_tristate         <= 1'b0;
      gate_brake_high       <= 1'b0;
      gate_brake_low        <= 1'b0;
    end else if (ce) begin
      fault_indicator_out_n <= !(uv_fault_reg || ov_fault_reg || lock_fault_reg); // [R10]
      gate_brake_high <= lock_fault_reg && (lock_action_reg == ACT_HIGH) &&
                         !uv_fault_reg && !ov_fault_reg;
      gate_brake_low  <= lock_fault_reg && (lock_action_reg == ACT_LOW) &&
                         !uv_fault_reg && !ov_fault_reg;
      gate_tristate   <= uv_fault_reg || ov_fault_reg ||
                         (lock_fault_reg && !lock_action_reg[1]); // [R9] [R10]
    end
  end

endmodule

/* sbf_pkg.sv */
// constants, register map and helpers for the supply bound fault configuration block
package sbf_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // deglitch counter sizing
  localparam int          DEG_W    = 11;
  localparam logic [10:0] DEG_STEP = 11'(CYC_PER_US);

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_FUNCTION_SETUP  = 8'hA4;
  localparam logic [7:0] IDX_DEVICE_SETUP_A      = 8'hA6;
  localparam logic [7:0] IDX_DEVICE_SETUP_B      = 8'hA8;
  localparam logic [7:0] IDX_PERIPHERAL_SETUP_A  = 8'hAA;
  localparam logic [7:0] IDX_GATE_DRIVER_SETUP_A = 8'hAC;
  localparam logic [7:0] IDX_GATE_DRIVER_SETUP_B = 8'hAE;
  localparam logic [7:0] IDX_FAULT_SETUP_B       = 8'h90;
  localparam logic [7:0] IDX_FAULT_STATUS        = 8'h92;
  localparam int         ADDR_W                  = 10;

  // fault_setup_b field layout
  localparam int LKM_LSB = 15;
  localparam int DEG_LSB = 12;
  localparam int MIN_LSB = 8;
  localparam int UVR_BIT = 7;
  localparam int MAX_LSB = 4;
  localparam int OVR_BIT = 3;
  localparam int RTY_LSB = 0;
  localparam logic [31:0] FAULT_B_MASK  = 32'h0007F7FF;
  localparam logic [31:0] FAULT_B_RESET = 32'h00000000;
  localparam logic [31:0] SETUP_RESET   = 32'h00000000;

  // fault_status layout
  localparam int ST_UV_BIT   = 0;
  localparam int ST_OV_BIT   = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_RPT_BIT  = 3;
  localparam int ST_CNT_LSB  = 4;
  localparam int CNT_W       = 5;

  // lock response codes
  localparam logic [3:0] LKM_REPORT = 4'h8;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_LOW    = 2'h3;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SBF_LK_IDLE  = 2'b00,
    SBF_LK_WAIT  = 2'b01,
    SBF_LK_LATCH = 2'b10
  } sbf_lock_state_t;

  // supply floor in millivolts, zero means no limit
  function automatic logic [15:0] sbf_floor_mv(input logic [2:0] code);
    case (code)
      3'h1:    sbf_floor_mv = 16'h1194;
      3'h2:    sbf_floor_mv = 16'h1388;
      3'h3:    sbf_floor_mv = 16'h157C;
      3'h4:    sbf_floor_mv = 16'h1770;
      3'h5:    sbf_floor_mv = 16'h1D4C;
      3'h6:    sbf_floor_mv = 16'h2710;
      3'h7:    sbf_floor_mv = 16'h30D4;
      default: sbf_floor_mv = 16'h0000;
    endcase
  endfunction

  // supply ceiling in millivolts, 20 V plus 2.5 V steps
  function automatic logic [15:0] sbf_ceiling_mv(input logic [2:0] code);
    case (code)
      3'h1:    sbf_ceiling_mv = 16'h4E20;
      3'h2:    sbf_ceiling_mv = 16'h57E4;
      3'h3:    sbf_ceiling_mv = 16'h61A8;
      3'h4:    sbf_ceiling_mv = 16'h6B6C;
      3'h5:    sbf_ceiling_mv = 16'h7530;
      3'h6:    sbf_ceiling_mv = 16'h7EF4;
      3'h7:    sbf_ceiling_mv = 16'h88B8;
      default: sbf_ceiling_mv = 16'hFFFF;
    endcase
  endfunction

  // retry attempts allowed, zero means unlimited
  function automatic logic [4:0] sbf_retry_limit(input logic [2:0] code);
    case (code)
      3'h1:    sbf_retry_limit = 5'h02;
      3'h2:    sbf_retry_limit = 5'h03;
      3'h3:    sbf_retry_limit = 5'h05;
      3'h4:    sbf_retry_limit = 5'h07;
      3'h5:    sbf_retry_limit = 5'h0A;
      3'h6:    sbf_retry_limit = 5'h0F;
      3'h7:    sbf_retry_limit = 5'h14;
      default: sbf_retry_limit = 5'h00;
    endcase
  endfunction

endpackage

/* sbf_lock_if.sv */
// carrier between the fault controller and its lock deglitch filter
`timescale 1ns/1ps
interface sbf_lock_if;
  logic       lock_raw;
  logic [2:0] lock_current_deglitch;
  logic       lock_seen;

  modport filt (
    input  lock_raw,
    input  lock_current_deglitch,
    output lock_seen
  );
  modport ctrl (
    output lock_raw,
    output lock_current_deglitch,
    input  lock_seen
  );
endinterface

/* sbf_lock_filter.sv */
// deglitch filter for the hardware lock current-limit detection
`timescale 1ns/1ps
module sbf_lock_filter
  import sbf_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  sbf_lock_if.filt  lk
);

  logic [DEG_W-1:0] cnt_reg;
  logic [DEG_W-1:0] target;
  logic             seen_reg;

  // code times one microsecond in cycles
  assign target = DEG_W'(lk.lock_current_deglitch) * DEG_STEP; // [R1]

  // restart on any drop so only a continuous condition counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= '0;
      seen_reg <= 1'b0;
    end else if (ce) begin
      if (!lk.lock_raw) begin
        cnt_reg  <= '0; // [R11]
        seen_reg <= 1'b0;
      end else if (cnt_reg >= target) begin
        seen_reg <= 1'b1; // [R1] [R11]
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign lk.lock_seen = seen_reg;

endmodule

/* sbf_chk.sv */
// port checker for the supply bound fault configuration block
`timescale 1ns/1ps
module sbf_chk
  import sbf_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        fault_indicator_out_n,
  input wire logic        gate_tristate,
  input wire logic        gate_brake_high,
  input wire logic        gate_brake_low
);
  logic take;
  logic rd_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a transfer is taken only with the bus ready and the block enabled
  assign take = ce && hready && hsel && htrans == HTRANS_NONSEQ;
  // remembers a read so its single wait cycle can be checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_q <= 1'b0;
    else rd_q <= take && !hwrite;
  end
  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_ready_idle: assert property (!rd_q |-> hreadyout)
    else $error("stall without read");
  a_rdata_hold: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved outside a read");
  a_brake_excl: assert property (!(gate_brake_high && gate_brake_low))
    else $error("both brakes on");
  a_tri_nobrake: assert property (gate_tristate |-> !gate_brake_high && !gate_brake_low)
    else $error("brake while tristated");
  a_gate_fault: assert property ((gate_tristate || gate_brake_high || gate_brake_low)
    |-> !fault_indicator_out_n)
    else $error("gate action without fault");
  c_read: cover property (take && !hwrite);
  c_fault: cover property ($fell(fault_indicator_out_n));
  c_brake_hi: cover property (gate_brake_high);
  c_brake_lo: cover property (gate_brake_low);
endmodule

bind sbf_fault_config sbf_chk u_chk (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .fault_indicator_out_n, .gate_tristate, .gate_brake_high,
  .gate_brake_low);

/* testbench.sv */
// self-checking testbench for the supply bound fault configuration block
`timescale 1ns/1ps
module testbench import sbf_pkg::*;;
  localparam int          RETRY = 20;
  localparam logic [31:0] A_CFG = 32'h00000240;
  localparam logic [31:0] A_ST  = 32'h00000248;
  logic        hclk, hresetn, hsel, hwrite, lock_detect;
  logic        hreadyout, hresp, f_n, g_t, g_bh, g_bl;
  logic [1:0]  htrans;
  logic [15:0] supply_mv;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, d;
  int          failures, num_checks, cycles, c, n, lim;
  int          fl [8] = '{0, 4500, 5000, 5500, 6000, 7500, 10000, 12500};
  int          rl [8] = '{0, 2, 3, 5, 7, 10, 15, 20};

  sbf_fault_config #(.LOCK_RETRY_CYCLES(RETRY)) u_dut (.hclk, .hresetn, .ce(1'h1), .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .supply_mv, .lock_detect, .fault_indicator_out_n(f_n),
    .gate_tristate(g_t), .gate_brake_high(g_bh), .gate_brake_low(g_bl));

  initial begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end
  // hang guard; the longest run is well under this
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // one single transfer; ready is sampled at each rising edge, read data at the last one
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // one supply bound: at the bound no fault, beyond it fault, then recovery or clear
  task automatic sup(input bit ov, input int k, input bit rec);
    int t;
    t = ov ? 20000 + 2500 * (k - 1) : fl[k];
    bus(1, A_CFG, ov ? (k << MAX_LSB) | (rec << OVR_BIT) : (k << MIN_LSB) | (rec << UVR_BIT));
    supply_mv <= 16'(t);
    cyc(4);
    chk(f_n, 1);
    supply_mv <= 16'(ov ? t + 1 + xs() % 50 : t - 1 - xs() % 50);
    cyc(4);
    chk({f_n, g_t}, 2'h1);
    bus(0, A_ST, 0);
    chk(rd, ov ? 2 : 1);
    supply_mv <= 16'(t);
    cyc(4);
    chk(f_n, rec);
    bus(1, A_ST, 3);
    cyc(3);
    chk(f_n, 1);
  endtask
  // lock setup, then lock_detect high for hi cycles
  task automatic lk(input logic [3:0] m, input int dg, input int hi, input int r);
    bus(1, A_CFG, (32'(m) << LKM_LSB) | (dg << DEG_LSB) | r);
    lock_detect <= 1'h1;
    cyc(hi);
    lock_detect <= 1'h0;
    cyc(5);
  endtask

  initial begin
    seed = 32'hCCFFD1F7;
    {failures, num_checks, cycles} = 0;
    {hresetn, hsel, hwrite, lock_detect, htrans, haddr, hwdata} = 0;
    supply_mv = 16'h5DC0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    // reset values, read/write setup words, unmapped place
    bus(0, A_CFG, 0);
    chk(rd, FAULT_B_RESET);
    bus(0, A_ST, 0);
    chk(rd, 0);
    for (int i = 0; i < 6; i++) begin
      bus(0, 32'h290 + 8 * i, 0);
      chk(rd, SETUP_RESET);
      d = xs();
      bus(1, 32'h290 + 8 * i, d);
      bus(0, 32'h290 + 8 * i, 0);
      chk(rd, d);
    end
    d = xs();
    bus(1, A_CFG, d);
    bus(0, A_CFG, 0);
    chk(rd, d & FAULT_B_MASK);
    bus(1, A_CFG, 0);
    bus(1, A_ST, 32'h0000000F);
    // reserved places are only read, never written
    bus(0, 32'h244, 0);
    chk(rd, 0);
    $display("test registers done");
    // no limit with code zero at either extreme of supply
    supply_mv <= 16'h0000;
    cyc(4);
    chk(f_n, 1);
    supply_mv <= 16'hFFFF;
    cyc(4);
    chk(f_n, 1);
    for (int k = 1; k < 8; k++) begin
      sup(0, k, 0);
      sup(1, k, 0);
    end
    sup(0, xs() % 7 + 1, 1);
    sup(1, xs() % 7 + 1, 1);
    // between every floor and every ceiling, so a stale bound cannot trip
    supply_mv <= 16'h3A98;
    $display("test supply done");
    // latched, report and disabled lock modes
    for (int i = 0; i < 6; i++) begin
      c = i < 4 ? i : 8 + i - 4;
      lk(c, 0, 8, 0);
      chk({g_t, g_bh, g_bl, f_n}, {c < 2, c == 2, c == 3, c > 3});
      bus(0, A_ST, 0);
      chk(rd, c < 4 ? 4 : c == 8 ? 8 : 0);
      bus(1, A_ST, 32'h0000000F);
      cyc(3);
      chk({g_t, f_n}, 2'h1);
    end
    $display("test lock modes done");
    // deglitch boundary: one cycle short restarts, exact length trips
    c = xs() % 7 + 1;
    n = c * CYC_PER_US + 1;
    lk(0, c, n - 1, 0);
    chk(f_n, 1);
    lk(0, c, n, 0);
    chk(f_n, 0);
    bus(1, A_ST, 4);
    $display("test deglitch done");
    // auto retry up to the limit, then latched with tristate
    c = xs() % 7 + 1;
    lim = rl[c];
    // any auto mode; the exceeded latch tristates whatever the brake choice
    n = 4 + xs() % 4;
    for (int i = 0; i <= lim; i++) begin
      lk(n, 0, 8, c);
      chk(f_n, 0);
      cyc(RETRY + 10);
      chk({f_n, g_t}, {i < lim, i == lim});
      bus(0, A_ST, 0);
      chk(rd, i < lim ? (i + 1) << ST_CNT_LSB : (lim << ST_CNT_LSB) | 4);
    end
    bus(1, A_ST, 4);
    bus(0, A_ST, 0);
    chk(rd, 0);
    $display("test retry done");
    summarize();
  end
endmodule
